// [core/dha_alu.sv]
// dual halfword add datapath with register port, accumulators and interrupt
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module dha_alu
    import dha_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [DHA_AW-1:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire dha_issue_s ISSUE,
    output logic MEM_RD,
    output logic [DHA_MAW-1:0] MEM_ADDR_MSW,
    output logic [DHA_MAW-1:0] MEM_ADDR_LSW,
    input wire logic [15:0] MEM_MSW,
    input wire logic [15:0] MEM_LSW,
    output logic DONE,
    output logic [3:0] ACOV,
    output logic CARRY,
    output logic IRQ
);

    logic [39:0] acc [4];
    logic [15:0] treg [4];
    dha_ctrl_s ctrl;
    logic [DHA_NEV-1:0] irq_stat;
    logic [DHA_NEV-1:0] irq_en;

    // operand-fetch stage
    logic s1_valid;
    logic s1_tmp_form;
    logic [1:0] s1_src;
    logic [1:0] s1_dst;

    // issue decode
    wire logic lead_ok = ISSUE.op[23:16] == DHA_OP_LEAD;
    wire logic is_acc_form = lead_ok && ISSUE.op[3:1] == DHA_OP_ACC_FORM;
    wire logic is_tmp_form = lead_ok && ISSUE.op[3:1] == DHA_OP_TMP_FORM;
    wire logic form_ok = is_acc_form || is_tmp_form;
    wire logic issue_take = ISSUE.valid && form_ok && !ISSUE.par;
    wire logic ev_illegal = ISSUE.valid && !form_ok;
    wire logic ev_par = ISSUE.valid && form_ok && ISSUE.par;

    // low word sits beside the high word inside the aligned pair
    wire logic [DHA_MAW-1:0] lsw_addr = ISSUE.addr[0] ?
        ISSUE.addr - DHA_MAW'(1) : ISSUE.addr + DHA_MAW'(1);

    // operand selection
    wire logic [39:0] src_acc = acc[s1_src];
    wire logic [15:0] src_tmp = treg[s1_src];
    wire logic sx = ctrl.sign_extension_mode_bit;
    wire logic legacy = ctrl.legacy_compat_mode_bit;
    wire logic [15:0] lo_a = MEM_LSW;
    wire logic [15:0] lo_b = s1_tmp_form ? src_tmp : src_acc[15:0];
    wire logic [23:0] hi_a = {{8{sx & MEM_MSW[15]}}, MEM_MSW};
    wire logic [23:0] tmp_dup = {{8{sx & src_tmp[15]}}, src_tmp};
    wire logic [23:0] hi_b = s1_tmp_form ? tmp_dup : src_acc[39:16];

    // low path, 16 bits with its own carry out
    wire logic [16:0] lo_sum = {lo_a[15], lo_a} + {lo_b[15], lo_b};
    wire logic [16:0] lo_uns = {1'b0, lo_a} + {1'b0, lo_b};
    wire logic lo_ovf_raw = lo_sum[16] != lo_sum[15];

    // carry crosses bit 15 only in legacy single-wide accumulator form
    wire logic wide = legacy && !ctrl.dual_word_arith_bit && !s1_tmp_form;
    wire logic cin = wide & lo_uns[16];

    // high path, 24 bits; bit 15 of this path is accumulator bit 31
    wire logic [24:0] hi_sum = {hi_a[23], hi_a} + {hi_b[23], hi_b} + {24'h000000, cin};
    wire logic [16:0] hi_c31 = {1'b0, hi_a[15:0]} + {1'b0, hi_b[15:0]} + {16'h0000, cin};
    wire logic hi_ovf = hi_sum[24:15] != {10{hi_sum[24]}};
    wire logic carry_out = hi_c31[16];

    // legacy mode hides low overflow and forces saturation off
    wire logic lo_ovf = lo_ovf_raw && !legacy;
    wire logic sat_on = ctrl.saturation_mode_bit && !legacy;
    wire logic any_ovf = lo_ovf || hi_ovf;

    wire logic [15:0] lo_res = (sat_on && lo_ovf) ?
        (lo_sum[16] ? DHA_LO_NEG_SAT : DHA_LO_POS_SAT) : lo_sum[15:0];
    wire logic [23:0] hi_res = (sat_on && hi_ovf) ?
        (hi_sum[24] ? DHA_HI_NEG_SAT : DHA_HI_POS_SAT) : hi_sum[23:0];
    wire logic [39:0] result = {hi_res, lo_res};

    // register port decode
    wire logic wr_ctrl = WR && ADDR == DHA_OFF_CTRL;
    wire logic wr_flags = WR && ADDR == DHA_OFF_FLAGS;
    wire logic wr_irq_clr = WR && ADDR == DHA_OFF_IRQ_CLR;
    wire logic wr_irq_en = WR && ADDR == DHA_OFF_IRQ_EN;
    wire logic [3:0] wr_treg;
    wire logic [3:0] wr_acc_lo;
    wire logic [3:0] wr_acc_hi;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_dec
            assign wr_treg[gi] = WR && ADDR == DHA_OFF_TREG0 + DHA_STEP_TREG * 8'(gi);
            assign wr_acc_lo[gi] = WR && ADDR == DHA_OFF_ACC0_LO + DHA_STEP_ACC * 8'(gi);
            assign wr_acc_hi[gi] = WR && ADDR == DHA_OFF_ACC0_HI + DHA_STEP_ACC * 8'(gi);
        end
    endgenerate

    // events; a set in the same cycle as a clear wins
    wire logic [DHA_NEV-1:0] events = {s1_valid, ev_par, ev_illegal,
        s1_valid & carry_out, s1_valid & any_ovf};
    wire logic [DHA_NEV-1:0] irq_clr = wr_irq_clr ? WDATA[DHA_NEV-1:0] : '0;
    wire logic [DHA_NEV-1:0] next_irq_stat = (irq_stat & ~irq_clr) | events;
    wire logic [DHA_NEV-1:0] next_irq_en = wr_irq_en ? WDATA[DHA_NEV-1:0] : irq_en;

    // overflow flags: software may clear, additions only ever set
    wire logic [3:0] acov_clr = wr_flags ? WDATA[3:0] : 4'h0;
    wire logic [3:0] acov_set = (s1_valid && any_ovf) ? 4'(1) << s1_dst : 4'h0;
    wire logic [3:0] next_acov = (ACOV & ~acov_clr) | acov_set;

    // carry follows each executed addition; a software write loses to it
    wire logic next_carry = s1_valid ? carry_out : (wr_flags ? WDATA[DHA_FLAG_CARRY] : CARRY);

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h00000000;
        unique case (ADDR)
            DHA_OFF_CTRL: rd_mux = {28'h0000000, ctrl};
            DHA_OFF_FLAGS: rd_mux = {27'h0000000, CARRY, ACOV};
            DHA_OFF_IRQ_STAT: rd_mux = {27'h0000000, irq_stat};
            DHA_OFF_IRQ_EN: rd_mux = {27'h0000000, irq_en};
            8'h20: rd_mux = {16'h0000, treg[0]};
            8'h24: rd_mux = {16'h0000, treg[1]};
            8'h28: rd_mux = {16'h0000, treg[2]};
            8'h2C: rd_mux = {16'h0000, treg[3]};
            8'h40: rd_mux = acc[0][31:0];
            8'h44: rd_mux = {24'h000000, acc[0][39:32]};
            8'h48: rd_mux = acc[1][31:0];
            8'h4C: rd_mux = {24'h000000, acc[1][39:32]};
            8'h50: rd_mux = acc[2][31:0];
            8'h54: rd_mux = {24'h000000, acc[2][39:32]};
            8'h58: rd_mux = acc[3][31:0];
            8'h5C: rd_mux = {24'h000000, acc[3][39:32]};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // issue stage: launches the long-operand read, one instruction per cycle
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            s1_valid <= 1'b0;
            s1_tmp_form <= 1'b0;
            s1_src <= 2'h0;
            s1_dst <= 2'h0;
            MEM_RD <= 1'b0;
            MEM_ADDR_MSW <= '0;
            MEM_ADDR_LSW <= '0;
        end else begin
            s1_valid <= issue_take;
            MEM_RD <= issue_take;
            if (issue_take) begin
                s1_tmp_form <= is_tmp_form;
                s1_src <= ISSUE.op[7:6];
                s1_dst <= ISSUE.op[5:4];
                MEM_ADDR_MSW <= ISSUE.addr;
                MEM_ADDR_LSW <= lsw_addr;
            end
        end
    end

    // execute: both halves written together in the one cycle
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < 4; i++) begin
                acc[i] <= 40'h0000000000;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (s1_valid && s1_dst == 2'(i)) begin
                    acc[i] <= result;
                end else if (wr_acc_lo[i]) begin
                    acc[i][31:0] <= WDATA;
                end else if (wr_acc_hi[i]) begin
                    acc[i][39:32] <= WDATA[7:0];
                end
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            for (int i = 0; i < 4; i++) begin
                treg[i] <= 16'h0000;
            end
            ctrl <= DHA_CTRL_RESET;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (wr_treg[i]) begin
                    treg[i] <= WDATA[15:0];
                end
            end
            if (wr_ctrl) begin
                ctrl <= WDATA[3:0];
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ACOV <= 4'h0;
            CARRY <= 1'b0;
            DONE <= 1'b0;
            irq_stat <= '0;
            irq_en <= '0;
            IRQ <= 1'b0;
            RDATA <= 32'h00000000;
        end else begin
            ACOV <= next_acov;
            CARRY <= next_carry;
            DONE <= s1_valid;
            irq_stat <= next_irq_stat;
            irq_en <= next_irq_en;
            // level from the same values the status will hold next cycle
            IRQ <= |(next_irq_stat & next_irq_en);
            RDATA <= RD ? rd_mux : 32'h00000000;
        end
    end

endmodule

// [include/dha_pkg.sv]
// constants, types and field layout for the dual halfword add datapath
// Contract
// - accumulator form: high = mem high + source high, low = mem low + source low.
// - temporary form: temporary value added to both memory high and memory low words.
// - forty-bit path split into independent 16-bit low and 24-bit high halves.
// - memory low word fed unchanged; high word extended to 24 bits by sign mode.
// - temporary feeds low path directly, duplicate extended to 24 bits feeds high.
// - high word at given address; low word at next if even, previous if odd.
// - each path checked for overflow; either sets the destination overflow flag.
// - low-path overflow taken at bit 15, high-path overflow at bit 31.
// - carry status comes only from the high path, at bit 31.
// - saturation on and low overflow: low clamps to 7FFF or 8000.
// - saturation on and high overflow: high clamps to 00_7FFF or FF_8000.
// - legacy mode set: never saturate, whatever the saturation bit holds.
// - legacy mode set: only high-path overflow reported; low-path overflow ignored.
// - legacy, accumulator form, dual-word bit 1: no carry across bit 15.
// - legacy, accumulator form, dual-word bit 0: carry passes across bit 15.
// - three-byte instruction, one execute cycle, parallel-enable marking refused.
// - leading byte 1110 1110; nibble 000x accumulator form, 100x temporary form.
// - repeated issues give identical per-iteration results and flag updates.
package dha_pkg;

    localparam int DHA_AW = 8;
    localparam int DHA_MAW = 16;

    // register byte offsets
    localparam logic [7:0] DHA_OFF_CTRL = 8'h00;
    localparam logic [7:0] DHA_OFF_FLAGS = 8'h04;
    localparam logic [7:0] DHA_OFF_IRQ_STAT = 8'h08;
    localparam logic [7:0] DHA_OFF_IRQ_CLR = 8'h0C;
    localparam logic [7:0] DHA_OFF_IRQ_EN = 8'h10;
    localparam logic [7:0] DHA_OFF_TREG0 = 8'h20;
    localparam logic [7:0] DHA_OFF_ACC0_LO = 8'h40;
    localparam logic [7:0] DHA_OFF_ACC0_HI = 8'h44;
    localparam logic [7:0] DHA_STEP_TREG = 8'h04;
    localparam logic [7:0] DHA_STEP_ACC = 8'h08;

    // control register fields
    localparam int DHA_CTRL_SATURATION_MODE_BIT = 0;
    localparam int DHA_CTRL_SIGN_EXTENSION_MODE_BIT = 1;
    localparam int DHA_CTRL_LEGACY = 2;
    localparam int DHA_CTRL_DUAL = 3;
    localparam logic [3:0] DHA_CTRL_RESET = 4'h2;

    // flag register fields: overflow flags in [3:0], carry at bit 4
    localparam int DHA_FLAG_CARRY = 4;

    // interrupt event bits
    localparam int DHA_EV_OVF = 0;
    localparam int DHA_EV_CARRY = 1;
    localparam int DHA_EV_ILLEGAL = 2;
    localparam int DHA_EV_PAR = 3;
    localparam int DHA_EV_DONE = 4;
    localparam int DHA_NEV = 5;

    // instruction encoding
    localparam logic [7:0] DHA_OP_LEAD = 8'hEE;
    localparam logic [2:0] DHA_OP_ACC_FORM = 3'h0;
    localparam logic [2:0] DHA_OP_TMP_FORM = 3'h4;

    // saturation values
    localparam logic [15:0] DHA_LO_POS_SAT = 16'h7FFF;
    localparam logic [15:0] DHA_LO_NEG_SAT = 16'h8000;
    localparam logic [23:0] DHA_HI_POS_SAT = 24'h007FFF;
    localparam logic [23:0] DHA_HI_NEG_SAT = 24'hFF8000;

    typedef struct packed {
        logic dual_word_arith_bit;
        logic legacy_compat_mode_bit;
        logic sign_extension_mode_bit;
        logic saturation_mode_bit;
    } dha_ctrl_s;

    typedef struct packed {
        logic valid;
        logic par;
        logic [23:0] op;
        logic [DHA_MAW-1:0] addr;
    } dha_issue_s;

endpackage

// [testbench/dha_alu_monitor.sv]
// port assertions for the dual halfword add datapath
`timescale 1ns/1ps
module dha_alu_monitor
    import dha_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic [DHA_AW-1:0] ADDR,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire dha_issue_s ISSUE,
    input wire logic MEM_RD,
    input wire logic [DHA_MAW-1:0] MEM_ADDR_MSW,
    input wire logic [DHA_MAW-1:0] MEM_ADDR_LSW,
    input wire logic DONE,
    input wire logic [3:0] ACOV,
    input wire logic CARRY
);
    default clocking @(posedge CLK);
    endclocking
    default disable iff (RST);
    wire ok_op = ISSUE.valid && !ISSUE.par && ISSUE.op[23:16] == DHA_OP_LEAD
        && (ISSUE.op[3:1] == DHA_OP_ACC_FORM || ISSUE.op[3:1] == DHA_OP_TMP_FORM);
    // flag writes may clear overflow or load carry, so they excuse a change
    wire flag_wr = WR && ADDR == DHA_OFF_FLAGS;
    a_issue_fetch: assert property (ok_op |=> MEM_RD && MEM_ADDR_MSW == $past(ISSUE.addr))
        else $error("accepted issue not fetched");
    a_marked_refused: assert property (ISSUE.valid && ISSUE.par |=> !MEM_RD)
        else $error("marked issue fetched");
    a_lsw_even: assert property (MEM_RD && !MEM_ADDR_MSW[0] |-> MEM_ADDR_LSW == MEM_ADDR_MSW + 16'h0001)
        else $error("even low word address");
    a_lsw_odd: assert property (MEM_RD && MEM_ADDR_MSW[0] |-> MEM_ADDR_LSW == MEM_ADDR_MSW - 16'h0001)
        else $error("odd low word address");
    a_done_next: assert property (MEM_RD |=> DONE)
        else $error("no done after fetch");
    a_acov_sticky: assert property (!$past(flag_wr) |-> (ACOV & $past(ACOV)) == $past(ACOV))
        else $error("overflow flag cleared");
    a_acov_on_done: assert property ((ACOV & ~$past(ACOV)) != 4'h0 |-> DONE)
        else $error("overflow flag set outside execute");
    a_carry_steady: assert property (!DONE && !$past(flag_wr) |-> $stable(CARRY))
        else $error("carry changed outside execute");
    a_rdata_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
        else $error("read data outside read slot");
endmodule
bind dha_alu dha_alu_monitor mon (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA),
    .ISSUE(ISSUE), .MEM_RD(MEM_RD), .MEM_ADDR_MSW(MEM_ADDR_MSW), .MEM_ADDR_LSW(MEM_ADDR_LSW), .DONE(DONE),
    .ACOV(ACOV), .CARRY(CARRY));

// [testbench/dha_mem_model.sv]
// data memory answering the long operand fetch
`timescale 1ns/1ps
module dha_mem_model
    import dha_pkg::*;
(
    input wire logic clk,
    input wire logic mem_rd,
    input wire logic [DHA_MAW-1:0] addr_msw,
    input wire logic [DHA_MAW-1:0] addr_lsw,
    output logic [15:0] mem_msw,
    output logic [15:0] mem_lsw,
    input wire logic load,
    input wire logic [7:0] load_addr,
    input wire logic [15:0] load_data
);
    logic [15:0] mem [256];
    logic [15:0] last_msw = 16'h0;
    logic [15:0] last_lsw = 16'h0;
    // outside a fetch the words flip, so a late sample cannot match by luck
    assign mem_msw = mem_rd ? mem[addr_msw[7:0]] : ~last_msw;
    assign mem_lsw = mem_rd ? mem[addr_lsw[7:0]] : ~last_lsw;
    always @(posedge clk) begin
        if (load) begin
            mem[load_addr] <= load_data;
        end
        if (mem_rd) begin
            last_msw <= mem_msw;
            last_lsw <= mem_lsw;
        end
    end
endmodule

// [testbench/dual_halfword_add_alu_test.sv]
// self-checking bench for the dual halfword add datapath
`timescale 1ns/1ps
module dual_halfword_add_alu_test;
    import dha_pkg::*;
    localparam logic [39:0] A0 = 40'h00_6000_9000;
    localparam logic [15:0] T0 = 16'h7000;
    logic CLK = 0, RST = 1, WR = 0, RD = 0, ld = 0, tf, MEM_RD, DONE, CARRY, IRQ;
    logic [7:0] ADDR = 0, la = 0, a;
    logic [31:0] WDATA = 0, RDATA, rv;
    logic [15:0] ldd = 0, MEM_MSW, MEM_LSW, MA, MB, mh, ml;
    logic [3:0] ACOV, c;
    logic [39:0] acc;
    logic [41:0] e;
    // control, temp form, memory high word, memory low word
    logic [36:0] rows [8] = '{{4'h2, 1'b0, 32'h1000_1000}, {4'h3, 1'b0, 32'h3000_9000}, {4'h2, 1'b0, 32'h3000_9000},
        {4'h0, 1'b0, 32'hF000_1000}, {4'h7, 1'b0, 32'h3000_9000}, {4'hF, 1'b0, 32'h3000_9000},
        {4'h3, 1'b1, 32'h2000_2000}, {4'h6, 1'b1, 32'h2000_2000}};
    dha_issue_s ISSUE = '0;
    int n_errors = 0, n_checks = 0, cyc = 0;
    always #12.5 CLK = ~CLK;
    dha_alu dut (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .ISSUE(ISSUE),
        .MEM_RD(MEM_RD), .MEM_ADDR_MSW(MA), .MEM_ADDR_LSW(MB), .MEM_MSW(MEM_MSW), .MEM_LSW(MEM_LSW), .DONE(DONE),
        .ACOV(ACOV), .CARRY(CARRY), .IRQ(IRQ));
    dha_mem_model mem (.clk(CLK), .mem_rd(MEM_RD), .addr_msw(MA), .addr_lsw(MB), .mem_msw(MEM_MSW),
        .mem_lsw(MEM_LSW), .load(ld), .load_addr(la), .load_data(ldd));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_errors = n_errors + 1;
            tally_and_finish();
        end
    end
    task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // strobes drop for a cycle so back-to-back calls never drive a signal twice at one edge
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        ADDR <= ad;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic rd(input logic [7:0] ad);
        ADDR <= ad;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        // read data stand only until the next edge: take them 1 ns after the launching edge, clear of it
        #1;
        rv = RDATA;
        @(posedge CLK);
    endtask
    task automatic ldm(input logic [7:0] ad, input logic [15:0] d);
        la <= ad;
        ldd <= d;
        ld <= 1'b1;
        @(posedge CLK);
        ld <= 1'b0;
        @(posedge CLK);
    endtask
    task automatic iss(input logic p, input logic [23:0] op, input logic [15:0] ad);
        ISSUE <= '{1'b1, p, op, ad};
        @(posedge CLK);
        ISSUE.valid <= 1'b0;
        repeat (3) @(posedge CLK);
    endtask
    task automatic rdacc();
        rd(DHA_OFF_ACC0_LO + DHA_STEP_ACC);
        acc[31:0] = rv;
        rd(DHA_OFF_ACC0_HI + DHA_STEP_ACC);
        acc[39:32] = rv[7:0];
    endtask
    function automatic logic [41:0] calc(input logic [3:0] k, input logic t, input logic [15:0] h, l);
        logic [23:0] eh, bh;
        logic [16:0] sl, ul, uh;
        logic [24:0] sh;
        logic ci, ovl, ovh, sat;
        eh = k[1] ? {{8{h[15]}}, h} : {8'h00, h};
        bh = !t ? A0[39:16] : k[1] ? {{8{T0[15]}}, T0} : {8'h00, T0};
        sl = {l[15], l} + (t ? {T0[15], T0} : {A0[15], A0[15:0]});
        ul = {1'b0, l} + {1'b0, t ? T0 : A0[15:0]};
        ci = k[2] && !k[3] && !t && ul[16];
        sh = {eh[23], eh} + {bh[23], bh} + 25'(ci);
        uh = {1'b0, eh[15:0]} + {1'b0, bh[15:0]} + 17'(ci);
        ovl = sl[16] != sl[15] && !k[2];
        ovh = sh[24:15] != '0 && sh[24:15] != '1;
        sat = k[0] && !k[2];
        calc[39:16] = sat && ovh ? (sh[24] ? DHA_HI_NEG_SAT : DHA_HI_POS_SAT) : sh[23:0];
        calc[15:0] = sat && ovl ? (sl[16] ? DHA_LO_NEG_SAT : DHA_LO_POS_SAT) : sl[15:0];
        calc[41:40] = {uh[16], ovl || ovh};
    endfunction
    initial begin
        repeat (6) @(posedge CLK);
        RST <= 1'b0;
        @(posedge CLK);
        rd(DHA_OFF_CTRL);
        chk("ctrl", 40'(DHA_CTRL_RESET), 40'(rv));
        rd(DHA_OFF_FLAGS);
        chk("flags", 40'h0, 40'(rv));
        rd(8'hFC);
        chk("unmapped", 40'h0, 40'(rv));
        wr(DHA_OFF_ACC0_LO, A0[31:0]);
        wr(DHA_OFF_ACC0_HI, 32'(A0[39:32]));
        wr(DHA_OFF_TREG0, 32'(T0));
        wr(DHA_OFF_IRQ_EN, 32'h1);
        $display("reset test done");
        foreach (rows[i]) begin
            {c, tf, mh, ml} = rows[i];
            a = 8'h20 + 8'(i);
            wr(DHA_OFF_CTRL, 32'(c));
            wr(DHA_OFF_FLAGS, 32'hF);
            ldm(a, mh);
            ldm(a[0] ? a - 8'h01 : a + 8'h01, ml);
            iss(1'b0, {16'hEE00, 4'h1, tf, 3'h0}, {8'h00, a});
            e = calc(c, tf, mh, ml);
            rdacc();
            chk("acc1", e[39:0], acc);
            chk("acov1", 40'(e[40]), 40'(ACOV[1]));
            chk("carry", 40'(e[41]), 40'(CARRY));
            $display("row %0d test done", i);
        end
        chk("irq raised", 40'h1, 40'(IRQ));
        wr(DHA_OFF_IRQ_CLR, 32'h1F);
        wr(DHA_OFF_IRQ_EN, 32'h0);
        ldm(8'h30, 16'h0);
        ldm(8'h31, 16'h0);
        // valid held two cycles: two issues back to back
        ISSUE <= '{1'b1, 1'b0, 24'hEE0010, 16'h0030};
        repeat (2) @(posedge CLK);
        ISSUE.valid <= 1'b0;
        repeat (4) @(posedge CLK);
        iss(1'b1, 24'hEE0010, 16'h0020);
        iss(1'b0, 24'hEF0010, 16'h0020);
        e = calc(4'h6, 1'b0, 16'h0, 16'h0);
        rdacc();
        chk("repeat acc1", e[39:0], acc);
        chk("sticky acov1", 40'h1, 40'(ACOV[1]));
        chk("irq masked", 40'h0, 40'(IRQ));
        rd(DHA_OFF_IRQ_STAT);
        chk("irq stat", 40'h1C, 40'(rv));
        wr(DHA_OFF_IRQ_EN, 32'h8);
        chk("irq enabled", 40'h1, 40'(IRQ));
        wr(DHA_OFF_IRQ_CLR, 32'h8);
        chk("irq cleared", 40'h0, 40'(IRQ));
        $display("awkward cases test done");
        tally_and_finish();
    end
endmodule
